// *** dv/dacmc_analog_model.sv ***
// Behavioural model of the analog stage: comparator sources and pulled-up comparator pin lines.
`timescale 1ns/1ps
module dacmc_analog_model (
    // Comparator levels requested by the bench.
    input wire logic [3:0] cmp_level,
    // Pin drivers from the device.
    input wire logic [3:0] pin_o,
    input wire logic [3:0] pin_oe,
    // Comparator results to the device and resolved pin lines.
    output logic [3:0] cmp_raw,
    output logic [3:0] pin_line
);
    // The board has a pull-up, so an undriven pin reads high rather than holding its last value.
    always_comb begin
        cmp_raw = cmp_level;
        for (int i = 0; i < 4; i++) begin
            pin_line[i] = pin_oe[i] ? pin_o[i] : 1'b1;
        end
    end
endmodule

// *** dv/dacmc_tb_top.sv ***
// Self-checking bench for the DAC channel mode control block.
`timescale 1ns/1ps
module dacmc_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dacmc_pkg::dacmc_chout_t [3:0] ana_o;
    logic int_ref_en_o;
    logic mode_input_disable_o;
    logic [3:0] cmp_level = 4'h0;
    logic [3:0] cmp_raw, pin_o, pin_oe, pin_line;
    logic [31:0] rd;
    logic er;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;

    dacmc_top u_dacmc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ana_o(ana_o),
        .int_ref_en_o(int_ref_en_o), .mode_input_disable_o(mode_input_disable_o), .cmp_raw_i(cmp_raw),
        .comparator_output_pin_o(pin_o), .comparator_output_pin_oe(pin_oe));
    dacmc_analog_model u_dacmc_analog_model (.cmp_level(cmp_level), .pin_o(pin_o), .pin_oe(pin_oe),
        .cmp_raw(cmp_raw), .pin_line(pin_line));

    // Clock at 250 MHz.
    always #2 pclk = ~pclk;

    // Watchdog: a hung handshake ends the run as a failure.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            test_done();
        end
    end

    // Prints the verdict and ends the run.
    task automatic test_done();
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compares one result against its expected value.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; the request stands until the rising edge at which pready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, err});
    endtask

    // Lets a register write reach the analog controls and the synchronised pins.
    task automatic settle();
        repeat (4) @(posedge pclk);
        #1;
    endtask

    function automatic logic [7:0] ca(input int ch, input logic [3:0] sub);
        return {4'(ch + 1), sub};
    endfunction

    // Reset values of registers and analog controls.
    task automatic t_reset();
        rdchk(dacmc_pkg::OFS_COMMON, 32'h0FFF, 1'b0);
        rdchk(dacmc_pkg::OFS_DEVMODE, 32'h0, 1'b0);
        chk(int_ref_en_o, 32'h0);
        for (int ch = 0; ch < 4; ch++) begin
            chk(ana_o[ch].ref_sel, dacmc_pkg::REF_EXT);
            chk(ana_o[ch].gain, dacmc_pkg::GN_X1);
            chk(ana_o[ch].fb_finite, 32'h0);
            chk({ana_o[ch].vout_en, ana_o[ch].iout_en}, 32'h0);
        end
        // The host picks the smallest current range before powering a channel in current mode.
        wr(ca(1, dacmc_pkg::SUB_IMISC), 32'h0);
        rdchk(ca(1, dacmc_pkg::SUB_IMISC), 32'h0, 1'b0);
    endtask

    // Voltage, current and neither mode side by side, with the internal reference on.
    task automatic t_modes();
        wr(dacmc_pkg::OFS_COMMON, 32'h19CC);
        settle();
        chk({ana_o[0].vout_en, ana_o[0].iout_en}, 32'h2);
        chk({ana_o[1].vout_en, ana_o[1].iout_en}, 32'h1);
        chk({ana_o[2].vout_en, ana_o[2].iout_en}, 32'h0);
        chk(int_ref_en_o, 32'h1);
        wr(dacmc_pkg::OFS_DEVMODE, 32'h1);
        settle();
        chk(mode_input_disable_o, 32'h1);
    endtask

    // Full-scale voltage code, current code truncation and range.
    task automatic t_codes();
        wr(ca(0, dacmc_pkg::SUB_DATA), 32'hFFF);
        wr(ca(1, dacmc_pkg::SUB_DATA), 32'hABC);
        wr(ca(1, dacmc_pkg::SUB_IMISC), 32'h5);
        settle();
        chk(ana_o[0].vcode, 32'hFFF);
        chk(ana_o[0].icode, 32'h0);
        chk(ana_o[1].icode, 32'hBC);
        chk(ana_o[1].vcode, 32'h0);
        chk(ana_o[1].range, 32'h5);
    endtask

    // Every gain-select code: reference and effective gain.
    task automatic t_gain();
        for (int g = 0; g < 8; g++) begin
            wr(ca(0, dacmc_pkg::SUB_VCMP), 32'(g));
            settle();
            chk(ana_o[0].ref_sel, (g == 1) ? 32'h1 : (g > 1 && g < 6) ? 32'h2 : 32'h0);
            chk(ana_o[0].gain, (g > 1 && g < 6) ? 32'(g - 1) : 32'h0);
        end
    endtask

    // All comparator bit combinations against both comparator levels.
    task automatic t_cmp();
        logic res;
        logic drv;
        for (int k = 0; k < 32; k++) begin
            cmp_level <= {3'b000, k[4]};
            wr(ca(0, dacmc_pkg::SUB_VCMP), 32'({k[3:0], 3'b000}));
            settle();
            res = k[4] ^ k[3];
            drv = k[0] & k[1];
            chk(ana_o[0].cmp_on, 32'(k[0]));
            chk(pin_oe[0], 32'(drv & (k[2] ? ~res : 1'b1)));
            chk(pin_line[0], 32'(drv ? res : 1'b1));
        end
        wr(ca(1, dacmc_pkg::SUB_VCMP), 32'h18);
        wr(ca(0, dacmc_pkg::SUB_VCMP), 32'h80);
        settle();
        chk(ana_o[1].cmp_on, 32'h0);
        chk(pin_oe[1], 32'h0);
        chk(ana_o[0].fb_finite, 32'h1);
    endtask

    // Per-channel comparator modes; the invalid code must leave the old mode in place.
    task automatic t_cmode();
        for (int ch = 0; ch < 4; ch++) begin
            wr(ca(ch, dacmc_pkg::SUB_CMODE), (ch == 3) ? 32'h2 : 32'(ch));
        end
        wr(ca(3, dacmc_pkg::SUB_CMODE), 32'h3);
        settle();
        for (int ch = 0; ch < 4; ch++) begin
            rdchk(ca(ch, dacmc_pkg::SUB_CMODE), (ch == 3) ? 32'h2 : 32'(ch), 1'b0);
            chk(ana_o[ch].cmode, (ch == 3) ? 32'h2 : 32'(ch));
        end
    endtask

    // Unmapped and unaligned accesses are refused.
    task automatic t_err();
        rdchk(8'h0C, 32'h0, 1'b1);
        rdchk(8'h11, 32'h0, 1'b1);
        wr(8'h50, 32'hFFFF);
        chk({31'h0, er}, 32'h1);
    endtask

    // Main sequence: reset for ten cycles, then every scenario in turn.
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_modes();
        t_codes();
        t_gain();
        t_cmp();
        t_cmode();
        t_err();
        test_done();
    end
endmodule

// *** rtl/dacmc_channel.sv ***
// One channel: mode decode, reference and gain, comparator pin driver.
`timescale 1ns/1ps
module dacmc_channel #(
    parameter int RES_BITS = 12
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Configuration from the register file and the raw comparator result.
    input dacmc_pkg::dacmc_chcfg_t cfg,
    input wire logic cmp_raw,
    // Analog controls, comparator pin and synchronised comparator result.
    output dacmc_pkg::dacmc_chout_t ana_r,
    output logic pin_o_r,
    output logic pin_oe_r,
    output logic cmp_sync_r
);
    logic cmp_s1_r;
    logic vmode;
    logic imode;
    logic res;
    logic drive;
    dacmc_pkg::dacmc_chout_t ana_nxt;
    localparam logic [dacmc_pkg::CODE_W-1:0] VMASK = dacmc_pkg::CODE_W'((1 << RES_BITS) - 1);

    // Decode the channel's mode, reference, gain and codes.
    always_comb begin
        vmode = (cfg.vpd == dacmc_pkg::VPD_UP) && cfg.ipd;
        imode = !cfg.ipd && (cfg.vpd == dacmc_pkg::VPD_HIZ);
        ana_nxt = '0;
        ana_nxt.vout_en = vmode;
        ana_nxt.iout_en = imode;
        ana_nxt.vcode = vmode ? (cfg.code & VMASK) : '0;
        ana_nxt.icode = imode ? cfg.code[dacmc_pkg::ICODE_W-1:0] : '0;
        ana_nxt.range = cfg.range;
        ana_nxt.cmp_on = vmode && cfg.vcmp[dacmc_pkg::VC_EN];
        ana_nxt.fb_finite = cfg.vcmp[dacmc_pkg::VC_FB];
        ana_nxt.cmode = cfg.cmode;
        ana_nxt.ref_sel = dacmc_pkg::REF_INT;
        case (cfg.vcmp[2:0])
            dacmc_pkg::GS_X1P5: ana_nxt.gain = dacmc_pkg::GN_X1P5;
            dacmc_pkg::GS_X2: ana_nxt.gain = dacmc_pkg::GN_X2;
            dacmc_pkg::GS_X3: ana_nxt.gain = dacmc_pkg::GN_X3;
            dacmc_pkg::GS_X4: ana_nxt.gain = dacmc_pkg::GN_X4;
            dacmc_pkg::GS_VDD: begin
                ana_nxt.ref_sel = dacmc_pkg::REF_VDD;
                ana_nxt.gain = dacmc_pkg::GN_X1;
            end
            default: begin
                ana_nxt.ref_sel = dacmc_pkg::REF_EXT;
                ana_nxt.gain = dacmc_pkg::GN_X1;
            end
        endcase
    end

    // Comparator result arrives asynchronously from the analog side.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_s1_r <= 1'b0;
            cmp_sync_r <= 1'b0;
        end else begin
            cmp_s1_r <= cmp_raw;
            cmp_sync_r <= cmp_s1_r;
        end
    end

    // Pin driver; open drain only ever pulls low, so the pin needs an external pull-up.
    assign res = cmp_sync_r ^ cfg.vcmp[dacmc_pkg::VC_INV];
    assign drive = ana_nxt.cmp_on && cfg.vcmp[dacmc_pkg::VC_PIN];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else if (!drive) begin
            pin_o_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else if (cfg.vcmp[dacmc_pkg::VC_OD]) begin
            pin_o_r <= 1'b0;
            pin_oe_r <= !res;
        end else begin
            pin_o_r <= res;
            pin_oe_r <= 1'b1;
        end
    end

    // Analog controls register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ana_r <= '0;
        end else begin
            ana_r <= ana_nxt;
        end
    end

    chk_vout_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.vpd == dacmc_pkg::VPD_UP && cfg.ipd) |=> (ana_r.vout_en && !ana_r.iout_en))
        else $error("Voltage mode not entered.");
    chk_iout_entry: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.vpd == dacmc_pkg::VPD_HIZ && !cfg.ipd) |=> (ana_r.iout_en && !ana_r.vout_en))
        else $error("Current mode not entered.");
    chk_vdd_unity: assert property (@(posedge clk) disable iff (!rst_n)
        ana_r.ref_sel == dacmc_pkg::REF_VDD |-> ana_r.gain == dacmc_pkg::GN_X1)
        else $error("Supply reference gain not unity.");
    chk_ext_unity: assert property (@(posedge clk) disable iff (!rst_n)
        ana_r.ref_sel == dacmc_pkg::REF_EXT |-> ana_r.gain == dacmc_pkg::GN_X1)
        else $error("External reference gain not unity.");
    chk_int_gain: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.vcmp[2:0] == dacmc_pkg::GS_X4 |=> ana_r.ref_sel == dacmc_pkg::REF_INT && ana_r.gain == dacmc_pkg::GN_X4)
        else $error("Internal 4x gain not applied.");
    chk_vcode_range: assert property (@(posedge clk) disable iff (!rst_n)
        ana_r.vcode <= VMASK)
        else $error("Voltage code exceeds resolution.");
    chk_icode_track: assert property (@(posedge clk) disable iff (!rst_n)
        imode |=> ana_r.icode == $past(cfg.code[dacmc_pkg::ICODE_W-1:0]))
        else $error("Current code not the low byte.");
    chk_cmp_gate: assert property (@(posedge clk) disable iff (!rst_n)
        !vmode |=> !ana_r.cmp_on && !pin_oe_r)
        else $error("Comparator active outside voltage mode.");
    chk_pin_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !cfg.vcmp[dacmc_pkg::VC_PIN] |=> !pin_oe_r && !pin_o_r)
        else $error("Pin driven while output disabled.");
    chk_od_low: assert property (@(posedge clk) disable iff (!rst_n)
        drive && cfg.vcmp[dacmc_pkg::VC_OD] |=> !pin_o_r && (pin_oe_r == !$past(res)))
        else $error("Open-drain drive wrong.");
    chk_pp_invert: assert property (@(posedge clk) disable iff (!rst_n)
        drive && !cfg.vcmp[dacmc_pkg::VC_OD] |=>
        pin_oe_r && pin_o_r == ($past(cmp_sync_r) ^ $past(cfg.vcmp[dacmc_pkg::VC_INV])))
        else $error("Push-pull level wrong.");
    chk_pin_on: assert property (@(posedge clk) disable iff (!rst_n)
        drive |=> pin_oe_r || cfg.vcmp[dacmc_pkg::VC_OD] || $past(cfg.vcmp[dacmc_pkg::VC_OD]))
        else $error("Enabled push-pull pin not driven.");
endmodule

// *** rtl/dacmc_pkg.sv ***
// Package with register map, field layouts and carrier types for the DAC channel mode control.
package dacmc_pkg;
    // Channel count and data widths.
    localparam int NCH = 4;
    localparam int CODE_W = 12;
    localparam int ICODE_W = 8;
    // Register byte offsets.
    localparam logic [7:0] OFS_COMMON = 8'h00;
    localparam logic [7:0] OFS_DEVMODE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [3:0] CH_FIRST = 4'h1;
    localparam logic [3:0] CH_LAST = 4'h4;
    localparam logic [3:0] SUB_DATA = 4'h0;
    localparam logic [3:0] SUB_VCMP = 4'h4;
    localparam logic [3:0] SUB_IMISC = 4'h8;
    localparam logic [3:0] SUB_CMODE = 4'hC;
    // Shared configuration layout: two power-down bits per channel, then current bits, then reference.
    localparam int COM_IPD_LSB = 8;
    localparam int COM_REF_BIT = 12;
    localparam int COM_W = 13;
    localparam logic [COM_W-1:0] COM_RST = 13'h0FFF;
    // Voltage and comparator configuration layout.
    localparam int VC_EN = 3;
    localparam int VC_PIN = 4;
    localparam int VC_OD = 5;
    localparam int VC_INV = 6;
    localparam int VC_FB = 7;
    localparam int VC_W = 8;
    localparam logic [VC_W-1:0] VC_RST = 8'h00;
    localparam int RNG_W = 4;
    localparam logic [RNG_W-1:0] RNG_RST = 4'h0;
    // Voltage power-down field encodings.
    typedef enum logic [1:0] {VPD_UP = 2'h0, VPD_10K = 2'h1, VPD_100K = 2'h2, VPD_HIZ = 2'h3} dacmc_vpd_t;
    // Gain and reference selection codes.
    typedef enum logic [2:0] {GS_EXT = 3'h0, GS_VDD = 3'h1, GS_X1P5 = 3'h2, GS_X2 = 3'h3,
        GS_X3 = 3'h4, GS_X4 = 3'h5} dacmc_gsel_t;
    typedef enum logic [2:0] {GN_X1 = 3'h0, GN_X1P5 = 3'h1, GN_X2 = 3'h2, GN_X3 = 3'h3, GN_X4 = 3'h4} dacmc_gain_t;
    typedef enum logic [1:0] {REF_EXT = 2'h0, REF_VDD = 2'h1, REF_INT = 2'h2} dacmc_ref_t;
    // Comparator mode field encodings; the last code is invalid.
    typedef enum logic [1:0] {CM_PLAIN = 2'h0, CM_HYST = 2'h1, CM_WIN = 2'h2, CM_BAD = 2'h3} dacmc_cmode_t;
    localparam logic [1:0] CM_RST = 2'h0;
    // Per-channel configuration as stored by software.
    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic [1:0] vpd;
        logic ipd;
        logic [VC_W-1:0] vcmp;
        logic [RNG_W-1:0] range;
        logic [1:0] cmode;
    } dacmc_chcfg_t;
    // Per-channel controls to the analog output stage.
    typedef struct packed {
        logic vout_en;
        logic iout_en;
        logic [1:0] ref_sel;
        logic [2:0] gain;
        logic [CODE_W-1:0] vcode;
        logic [ICODE_W-1:0] icode;
        logic [RNG_W-1:0] range;
        logic cmp_on;
        logic fb_finite;
        logic [1:0] cmode;
    } dacmc_chout_t;
endpackage

// *** rtl/dacmc_top.sv ***
// Register file over APB and four channel mode decoders for the quad DAC.
//
// How it works
// - Voltage mode: voltage path up, current down.
// - Current mode: current path on, voltage Hi-Z.
// - Internal reference off after reset, 1 enables.
// - Internal reference gains 1.5x, 2x, 3x, 4x.
// - External reference by default, gain fixed 1x.
// - Supply reference forces gain 1x.
// - Voltage code is N-bit, 10 or 12.
// - Current mode uses an 8-bit code.
// - Current range field selects output range.
// - Comparator needs voltage mode and enable bit.
// - Output-enable bit gates the comparator pin.
// - Open-drain bit: 0 push-pull, 1 open-drain.
// - Invert bit inverts result in both drives.
// - Feedback input Hi-Z after reset, 1 enables.
// - Comparator mode field chosen per channel.
// - Modes 00, 01, 10; 11 invalid.
`timescale 1ns/1ps
module dacmc_top #(
    parameter int RES_BITS = 12
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Analog output stage.
    output dacmc_pkg::dacmc_chout_t [dacmc_pkg::NCH-1:0] ana_o,
    output logic int_ref_en_o,
    output logic mode_input_disable_o,
    // Comparator results and pins.
    input wire logic [dacmc_pkg::NCH-1:0] cmp_raw_i,
    output logic [dacmc_pkg::NCH-1:0] comparator_output_pin_o,
    output logic [dacmc_pkg::NCH-1:0] comparator_output_pin_oe
);
    logic [dacmc_pkg::COM_W-1:0] common_r;
    logic devmode_r;
    logic [dacmc_pkg::CODE_W-1:0] code_r [dacmc_pkg::NCH];
    logic [dacmc_pkg::VC_W-1:0] vcmp_r [dacmc_pkg::NCH];
    logic [dacmc_pkg::RNG_W-1:0] range_r [dacmc_pkg::NCH];
    logic [1:0] cmode_r [dacmc_pkg::NCH];
    logic [dacmc_pkg::NCH-1:0] cmp_sync;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic hit;
    logic is_ch;
    logic [1:0] ch_idx;
    logic [3:0] sub;
    logic setup;
    logic commit;
    logic [dacmc_pkg::VC_W-1:0] wvc;

    // Channel window decode: one 16-byte block per channel after the shared block.
    assign is_ch = (paddr[7:4] >= dacmc_pkg::CH_FIRST) && (paddr[7:4] <= dacmc_pkg::CH_LAST);
    assign ch_idx = 2'(paddr[7:4] - dacmc_pkg::CH_FIRST);
    assign sub = paddr[3:0];
    assign setup = psel && !penable;
    assign commit = psel && penable && pready_r && pwrite && hit;
    assign wvc = pwdata[dacmc_pkg::VC_W-1:0];

    // Read mux and address check; unused bits read as zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == dacmc_pkg::OFS_COMMON) begin
            rdata_nxt[dacmc_pkg::COM_W-1:0] = common_r;
        end else if (paddr == dacmc_pkg::OFS_DEVMODE) begin
            rdata_nxt[0] = devmode_r;
        end else if (paddr == dacmc_pkg::OFS_STATUS) begin
            for (int i = 0; i < dacmc_pkg::NCH; i++) begin
                rdata_nxt[i] = ana_o[i].vout_en;
                rdata_nxt[4 + i] = ana_o[i].iout_en;
                rdata_nxt[8 + i] = ana_o[i].cmp_on;
                rdata_nxt[12 + i] = cmp_sync[i];
            end
        end else if (is_ch && sub == dacmc_pkg::SUB_DATA) begin
            rdata_nxt[dacmc_pkg::CODE_W-1:0] = code_r[ch_idx];
        end else if (is_ch && sub == dacmc_pkg::SUB_VCMP) begin
            rdata_nxt[dacmc_pkg::VC_W-1:0] = vcmp_r[ch_idx];
        end else if (is_ch && sub == dacmc_pkg::SUB_IMISC) begin
            rdata_nxt[dacmc_pkg::RNG_W-1:0] = range_r[ch_idx];
        end else if (is_ch && sub == dacmc_pkg::SUB_CMODE) begin
            rdata_nxt[1:0] = cmode_r[ch_idx];
        end else begin
            hit = 1'b0;
        end
    end

    // Zero-wait APB answer: ready rises in the access phase after every setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (setup) begin
            pready_r <= 1'b1;
            pslverr_r <= !hit;
            prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
        end else begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    // Shared configuration: all channels Hi-Z, current paths down, internal reference off.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            common_r <= dacmc_pkg::COM_RST;
        end else if (commit && paddr == dacmc_pkg::OFS_COMMON) begin
            common_r <= pwdata[dacmc_pkg::COM_W-1:0];
        end
    end
    assign int_ref_en_o = common_r[dacmc_pkg::COM_REF_BIT];

    // Mode-input disable is only stored and passed on; the host decides when to set it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            devmode_r <= 1'b0;
        end else if (commit && paddr == dacmc_pkg::OFS_DEVMODE) begin
            devmode_r <= pwdata[0];
        end
    end
    assign mode_input_disable_o = devmode_r;

    // Per-channel registers and decoders.
    for (genvar g = 0; g < dacmc_pkg::NCH; g++) begin : gen_ch
        dacmc_pkg::dacmc_chcfg_t cfg;

        // Code, gain and comparator controls, current range.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                code_r[g] <= '0;
                vcmp_r[g] <= dacmc_pkg::VC_RST;
                range_r[g] <= dacmc_pkg::RNG_RST;
            end else if (commit && is_ch && ch_idx == 2'(g)) begin
                if (sub == dacmc_pkg::SUB_DATA) begin
                    code_r[g] <= pwdata[dacmc_pkg::CODE_W-1:0];
                end
                if (sub == dacmc_pkg::SUB_VCMP) begin
                    vcmp_r[g] <= wvc;
                end
                if (sub == dacmc_pkg::SUB_IMISC) begin
                    range_r[g] <= pwdata[dacmc_pkg::RNG_W-1:0];
                end
            end
        end

        // The invalid comparator mode is dropped so the analog side never sees it.
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cmode_r[g] <= dacmc_pkg::CM_RST;
            end else if (commit && is_ch && ch_idx == 2'(g) && sub == dacmc_pkg::SUB_CMODE &&
                         pwdata[1:0] != dacmc_pkg::CM_BAD) begin
                cmode_r[g] <= pwdata[1:0];
            end
        end

        // Gather the channel's configuration for its decoder.
        always_comb begin
            cfg.code = code_r[g];
            cfg.vpd = common_r[2 * g +: 2];
            cfg.ipd = common_r[dacmc_pkg::COM_IPD_LSB + g];
            cfg.vcmp = vcmp_r[g];
            cfg.range = range_r[g];
            cfg.cmode = cmode_r[g];
        end

        dacmc_channel #(
            .RES_BITS(RES_BITS)
        ) u_ch (
            .clk(pclk),
            .rst_n(presetn),
            .cfg(cfg),
            .cmp_raw(cmp_raw_i[g]),
            .ana_r(ana_o[g]),
            .pin_o_r(comparator_output_pin_o[g]),
            .pin_oe_r(comparator_output_pin_oe[g]),
            .cmp_sync_r(cmp_sync[g])
        );

        chk_range_load: assert property (@(posedge pclk) disable iff (!presetn)
            commit && is_ch && ch_idx == 2'(g) && sub == dacmc_pkg::SUB_IMISC
            |=> ##1 ana_o[g].range == $past(pwdata[dacmc_pkg::RNG_W-1:0], 2))
            else $error("Current range not applied.");
        chk_mode_valid: assert property (@(posedge pclk) disable iff (!presetn)
            cmode_r[g] != dacmc_pkg::CM_BAD)
            else $error("Invalid comparator mode stored.");
        chk_mode_indep: assert property (@(posedge pclk) disable iff (!presetn)
            commit && !(is_ch && ch_idx == 2'(g)) |=> $stable(cmode_r[g]))
            else $error("Comparator mode changed by another channel.");
    end

    chk_ref_reset: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) || !(commit && paddr == dacmc_pkg::OFS_COMMON) |=> $stable(int_ref_en_o))
        else $error("Reference enable changed without a write.");
    chk_ref_write: assert property (@(posedge pclk) disable iff (!presetn)
        commit && paddr == dacmc_pkg::OFS_COMMON && pwdata[dacmc_pkg::COM_REF_BIT] |=> int_ref_en_o)
        else $error("Reference enable write lost.");
    chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready && (pslverr == !$past(hit)))
        else $error("APB answer late or wrong.");
endmodule
